// ==== ee_pkg.sv ====
`default_nettype none
package ee_pkg;
  localparam int CLK_NS     = 50;
  // Longest times round down, least times round up.
  localparam int WR_TIME_NS = 4_000_000;
  localparam int WR_CYC     = WR_TIME_NS / CLK_NS;
  localparam int PU_TIME_NS = 350_000;
  localparam int PU_CYC     = PU_TIME_NS / CLK_NS;
  localparam int GLITCH_NS  = 50;
  localparam int GLITCH_CYC = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOST_QTR   = 4;
  localparam logic [3:0] DEV_TYPE = 4'ha;
  localparam int MEM_AW     = 12;
  localparam int PAGE_AW    = 5;
  localparam int PAGE_BYTES = 32;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_WP  = 2;
  localparam int PIN_POR = 3;
  localparam int PIN_S0  = 4;
  localparam int PIN_N   = 7;
  typedef enum logic [2:0] {
    EE_IDLE   = 3'b000,
    EE_DEVADR = 3'b001,
    EE_ADRH   = 3'b010,
    EE_ADRL   = 3'b011,
    EE_DATA   = 3'b100,
    EE_READ   = 3'b101
  } ee_dst_e;
  typedef enum logic [2:0] {
    EH_PU    = 3'b000,
    EH_IDLE  = 3'b001,
    EH_NEXT  = 3'b010,
    EH_START = 3'b011,
    EH_BIT   = 3'b100,
    EH_STOP  = 3'b101
  } ee_hst_e;
  typedef enum logic [1:0] {
    OP_S = 2'b00,
    OP_T = 2'b01,
    OP_R = 2'b10,
    OP_P = 2'b11
  } ee_op_e;
endpackage : ee_pkg
`default_nettype wire

// ==== ee_if.sv ====
`default_nettype none
interface ee_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  // Open-drain wired AND with pull-ups.
  assign scl = ~(host_scl_oe & ~host_scl_o);
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
  modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
                output host_sda_o, output host_sda_oe);
endinterface : ee_if
`default_nettype wire

// ==== ee_deglitch.sv ====
`default_nettype none
module ee_deglitch
  import ee_pkg::*;
#(
  parameter int   N       = GLITCH_CYC,
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic pin_i,
  output logic      q_o
);
  logic       s1_r;
  logic       s2_r;
  logic [7:0] cnt_r;

  always_ff @(posedge clk_i) begin
    s1_r <= pin_i;
    s2_r <= s1_r;
  end

  // A new level must persist past the glitch width before it is passed on.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      q_o   <= RST_VAL;
      cnt_r <= 8'h00;
    end else if (s2_r == q_o) begin
      cnt_r <= 8'h00;
    end else if (cnt_r == 8'(N)) begin
      q_o   <= s2_r;
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule : ee_deglitch
`default_nettype wire

// ==== ee_dev.sv ====
// Contract
// - Sample on clock rise, drive on fall.
// - Data output is open drain.
// - Falling data, clock high is START.
// - Rising data, clock high is STOP.
// - Data stable while clock is high.
// - Master alone clocks and starts transfers.
// - Address byte 1010 plus three strap bits.
// - Address LSB: one read, zero write.
// - Ninth clock carries acknowledge from receiver.
// - Byte write: address, two addresses, data, STOP.
// - Acknowledge every byte of a write; data bytes are not acknowledged when sampled protect is high.
// - STOP starts write cycle; silent while busy.
// - Write protect high refuses all writes.
// - Power detector holds and releases reset.
// - Ready within power-up delay after supply.
// - Filter glitches up to 50 ns.
// - Sample protect before first data byte.
// - Page buffer of 32 bytes, wrapping.
// - Read streams bytes while master acknowledges.
// - Selective read: dummy write, repeated START.
`default_nettype none
module ee_dev
  import ee_pkg::*;
#(
  parameter int WR_CYCLES = WR_CYC,
  parameter int PU_CYCLES = PU_CYC,
  parameter int AW        = MEM_AW
) (
  input  wire logic          clk_i,
  input  wire logic          sys_rst_i,
  ee_if.dev                  bus,
  input  wire logic          por_ok_i,
  input  wire logic          wp_i,
  input  wire logic          select_strap_bit0_i,
  input  wire logic          select_strap_bit1_i,
  input  wire logic          select_strap_bit2_i,
  output logic               mem_we_o,
  output logic [AW-1:0]      mem_waddr_o,
  output logic [7:0]         mem_wdata_o,
  output logic [AW-1:0]      mem_raddr_o,
  input  wire logic [7:0]    mem_rdata_i,
  output logic               busy_o,
  output logic               ready_o
);
  ////////////////////////////////////////////////////////////////////////////
  wire logic [PIN_N-1:0] raw = {select_strap_bit2_i, select_strap_bit1_i,
                                select_strap_bit0_i, por_ok_i, wp_i,
                                bus.sda, bus.scl};
  logic [PIN_N-1:0] filt;

  for (genvar g = 0; g < PIN_N; g++) begin : g_pin
    ee_deglitch #(
      .N       (GLITCH_CYC),
      .RST_VAL (1'(g <= PIN_SDA))
    ) u_flt (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .pin_i     (raw[g]),
      .q_o       (filt[g])
    );
  end

  wire logic       rst   = sys_rst_i | ~filt[PIN_POR];
  wire logic       scl   = filt[PIN_SCL];
  wire logic       sda   = filt[PIN_SDA];
  wire logic [2:0] strap = filt[PIN_S0+2:PIN_S0];

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] pu_cnt_r;
  logic        ready_r;

  // Bus is ignored until the power-up delay has run out.
  always_ff @(posedge clk_i) begin
    if (rst) begin
      pu_cnt_r <= 32'h0;
      ready_r  <= 1'b0;
    end else if (!ready_r) begin
      pu_cnt_r <= pu_cnt_r + 32'h1;
      ready_r  <= (pu_cnt_r == 32'(PU_CYCLES - 1));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic scl_q_r;
  logic sda_q_r;

  always_ff @(posedge clk_i) begin
    scl_q_r <= scl;
    sda_q_r <= sda;
  end

  wire logic scl_rise = scl & ~scl_q_r;
  wire logic scl_fall = ~scl & scl_q_r;
  wire logic start_c  = scl & scl_q_r & sda_q_r & ~sda;
  wire logic stop_c   = scl & scl_q_r & ~sda_q_r & sda;

  ////////////////////////////////////////////////////////////////////////////
  ee_dst_e         st_r;
  logic [3:0]      cnt_r;
  logic            ackph_r;
  logic [7:0]      sr_r;
  logic            drv_r;
  logic            nack_r;
  logic            rw_r;
  logic            mack_r;
  logic            wp_r;
  logic            wr_pend_r;
  logic [AW-1:0]   addr_r;
  logic [PAGE_BYTES-1:0] pmask_r;
  logic [7:0]      pbuf [PAGE_BYTES];
  logic            busy_r;
  logic [PAGE_AW:0] cm_idx_r;
  logic [31:0]     wt_r;

  wire logic dev_hit = (sr_r[7:4] == DEV_TYPE) && (sr_r[3:1] == strap) && !busy_r;
  wire logic ack_ok  = (st_r == EE_DEVADR) ? dev_hit :
                       (st_r == EE_DATA)   ? ~wp_r   : 1'b1;
  wire logic byte_end = scl_fall && (cnt_r == ACK_SLOT) && !ackph_r;
  wire logic slot_end = scl_fall && (cnt_r == ACK_SLOT) && ackph_r;
  wire logic pbuf_we  = byte_end && (st_r == EE_DATA) && !wp_r;
  wire ee_dst_e nxt_st = (st_r == EE_DEVADR) ? (rw_r ? EE_READ : EE_ADRH) :
                         (st_r == EE_ADRH)   ? EE_ADRL : EE_DATA;
  wire logic launch  = stop_c && wr_pend_r && ready_r;

  always_ff @(posedge clk_i) begin
    if (rst) begin
      st_r      <= EE_IDLE;
      cnt_r     <= 4'h0;
      ackph_r   <= 1'b0;
      sr_r      <= 8'h00;
      drv_r     <= 1'b0;
      nack_r    <= 1'b0;
      rw_r      <= 1'b0;
      mack_r    <= 1'b1;
      wp_r      <= 1'b0;
      wr_pend_r <= 1'b0;
      addr_r    <= '0;
      pmask_r   <= '0;
    end else if (!ready_r) begin
      st_r <= EE_IDLE;
    end else if (start_c) begin
      // A repeated START drops any unfinished page load.
      st_r      <= EE_DEVADR;
      cnt_r     <= 4'h0;
      ackph_r   <= 1'b0;
      drv_r     <= 1'b0;
      wr_pend_r <= 1'b0;
    end else if (stop_c) begin
      st_r      <= EE_IDLE;
      ackph_r   <= 1'b0;
      drv_r     <= 1'b0;
      wr_pend_r <= 1'b0;
    end else if (st_r == EE_READ) begin
      if (scl_rise && ackph_r) begin
        mack_r <= sda;
      end
      if (scl_fall && ackph_r) begin
        if (mack_r) begin
          st_r    <= EE_IDLE;
          drv_r   <= 1'b0;
          ackph_r <= 1'b0;
        end else begin
          sr_r    <= {mem_rdata_i[6:0], 1'b0};
          drv_r   <= ~mem_rdata_i[7];
          addr_r  <= addr_r + AW'(1);
          cnt_r   <= 4'h1;
          ackph_r <= 1'b0;
        end
      end else if (scl_fall && cnt_r == ACK_SLOT) begin
        drv_r   <= 1'b0;
        ackph_r <= 1'b1;
      end else if (scl_fall) begin
        drv_r <= ~sr_r[7];
        sr_r  <= {sr_r[6:0], 1'b0};
        cnt_r <= cnt_r + 4'h1;
      end
    end else if (st_r != EE_IDLE) begin
      if (scl_rise && !ackph_r && cnt_r != ACK_SLOT) begin
        sr_r  <= {sr_r[6:0], sda};
        cnt_r <= cnt_r + 4'h1;
      end
      if (byte_end) begin
        ackph_r <= 1'b1;
        drv_r   <= ack_ok;
        nack_r  <= ~ack_ok;
        if (st_r == EE_DEVADR) begin
          rw_r <= sr_r[0];
        end
        if (st_r == EE_ADRH) begin
          addr_r[AW-1:8] <= sr_r[AW-9:0];
        end
        if (st_r == EE_ADRL) begin
          addr_r[7:0] <= sr_r;
        end
        if (pbuf_we) begin
          addr_r[PAGE_AW-1:0] <= addr_r[PAGE_AW-1:0] + PAGE_AW'(1);
          pmask_r[addr_r[PAGE_AW-1:0]] <= 1'b1;
          wr_pend_r <= 1'b1;
        end
      end
      if (slot_end) begin
        ackph_r <= 1'b0;
        cnt_r   <= 4'h0;
        drv_r   <= 1'b0;
        st_r    <= nack_r ? EE_IDLE : nxt_st;
        if (st_r == EE_ADRL) begin
          wp_r    <= filt[PIN_WP];
          pmask_r <= '0;
        end
        if (!nack_r && nxt_st == EE_READ) begin
          sr_r   <= {mem_rdata_i[6:0], 1'b0};
          drv_r  <= ~mem_rdata_i[7];
          addr_r <= addr_r + AW'(1);
          cnt_r  <= 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (pbuf_we) begin
      pbuf[addr_r[PAGE_AW-1:0]] <= sr_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The commit walks the whole page once while the timer holds the device
  // busy for the full write time; WR_CYCLES must be at least PAGE_BYTES.
  always_ff @(posedge clk_i) begin
    if (rst) begin
      busy_r      <= 1'b0;
      cm_idx_r    <= '0;
      wt_r        <= 32'h0;
      mem_we_o    <= 1'b0;
      mem_waddr_o <= '0;
      mem_wdata_o <= 8'h00;
    end else begin
      mem_we_o <= busy_r && !cm_idx_r[PAGE_AW] && pmask_r[cm_idx_r[PAGE_AW-1:0]];
      mem_waddr_o <= {addr_r[AW-1:PAGE_AW], cm_idx_r[PAGE_AW-1:0]};
      mem_wdata_o <= pbuf[cm_idx_r[PAGE_AW-1:0]];
      if (!busy_r) begin
        busy_r   <= launch;
        cm_idx_r <= '0;
        wt_r     <= 32'h0;
      end else begin
        wt_r <= wt_r + 32'h1;
        if (!cm_idx_r[PAGE_AW]) begin
          cm_idx_r <= cm_idx_r + (PAGE_AW+1)'(1);
        end
        if (wt_r == 32'(WR_CYCLES - 1)) begin
          busy_r <= 1'b0;
        end
      end
    end
  end

  assign bus.dev_sda_o  = 1'b0;
  assign bus.dev_sda_oe = drv_r & ~busy_r;
  assign mem_raddr_o    = addr_r;
  assign busy_o         = busy_r;
  assign ready_o        = ready_r;
endmodule : ee_dev
`default_nettype wire

// ==== ee_host.sv ====
`default_nettype none
module ee_host
  import ee_pkg::*;
#(
  parameter int QTR       = HOST_QTR,
  parameter int PU_CYCLES = PU_CYC,
  parameter int AW        = MEM_AW
) (
  input  wire logic          clk_i,
  input  wire logic          sys_rst_i,
  ee_if.host                 bus,
  input  wire logic          cmd_valid_i,
  output logic               cmd_ready_o,
  input  wire logic          cmd_read_i,
  input  wire logic [2:0]    cmd_dev_i,
  input  wire logic [AW-1:0] cmd_addr_i,
  input  wire logic [7:0]    cmd_wdata_i,
  output logic               rsp_valid_o,
  output logic               rsp_nack_o,
  output logic [7:0]         rsp_rdata_o
);
  logic sda;

  ee_deglitch #(
    .N       (GLITCH_CYC),
    .RST_VAL (1'b1)
  ) u_flt (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (bus.sda),
    .q_o       (sda)
  );

  ee_hst_e       st_r;
  logic [1:0]    ph_r;
  logic [15:0]   qc_r;
  logic [31:0]   pu_cnt_r;
  logic [2:0]    step_r;
  logic [3:0]    bit_r;
  logic          rd_r;
  logic [2:0]    dev_r;
  logic [AW-1:0] addr_r;
  logic [7:0]    wd_r;
  logic [7:0]    sr_r;
  logic          scl_lo_r;
  logic          sda_lo_r;

  // Selective read is a dummy write of the address, then a repeated START.
  wire logic [2:0] last_c = rd_r ? 3'd7 : 3'd5;
  wire ee_op_e op_c = (step_r == 3'd0 || (rd_r && step_r == 3'd4)) ? OP_S :
                      (step_r == last_c)             ? OP_P :
                      (rd_r && step_r == 3'd6)       ? OP_R : OP_T;
  wire logic [15:0] ahi = 16'(addr_r) >> 8;
  wire logic [7:0] txb_c = (step_r == 3'd1) ? {DEV_TYPE, dev_r, 1'b0} :
                           (step_r == 3'd5) ? {DEV_TYPE, dev_r, 1'b1} :
                           (step_r == 3'd2) ? ahi[7:0] :
                           (step_r == 3'd3) ? addr_r[7:0] : wd_r;
  wire logic tick = (qc_r == 16'(QTR - 1));

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_r <= EH_PU;
      ph_r <= 2'b00;
      qc_r <= 16'h0;
      pu_cnt_r <= 32'h0;
      step_r <= 3'd0;
      bit_r <= 4'h0;
      rd_r <= 1'b0;
      dev_r <= 3'b000;
      addr_r <= '0;
      wd_r <= 8'h00;
      sr_r <= 8'h00;
      scl_lo_r <= 1'b0;
      sda_lo_r <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_nack_o <= 1'b0;
      rsp_rdata_o <= 8'h00;
    end else begin
      rsp_valid_o <= 1'b0;
      qc_r <= tick ? 16'h0 : qc_r + 16'h1;
      if (tick) begin
        ph_r <= ph_r + 2'b01;
      end
      case (st_r)
        EH_PU: begin
          pu_cnt_r <= pu_cnt_r + 32'h1;
          if (pu_cnt_r == 32'(PU_CYCLES - 1)) begin
            st_r <= EH_IDLE;
          end
        end
        EH_IDLE: begin
          if (cmd_valid_i) begin
            rd_r <= cmd_read_i;
            dev_r <= cmd_dev_i;
            addr_r <= cmd_addr_i;
            wd_r <= cmd_wdata_i;
            step_r <= 3'd0;
            rsp_nack_o <= 1'b0;
            st_r <= EH_NEXT;
          end
        end
        EH_NEXT: begin
          qc_r <= 16'h0;
          ph_r <= 2'b00;
          bit_r <= 4'h0;
          sr_r <= txb_c;
          st_r <= (op_c == OP_S) ? EH_START : (op_c == OP_P) ? EH_STOP : EH_BIT;
        end
        EH_START: begin
          if (tick) begin
            case (ph_r)
              2'b00: sda_lo_r <= 1'b0;
              2'b01: scl_lo_r <= 1'b0;
              2'b10: sda_lo_r <= 1'b1;
              default: begin
                scl_lo_r <= 1'b1;
                step_r <= step_r + 3'd1;
                st_r <= EH_NEXT;
              end
            endcase
          end
        end
        EH_BIT: begin
          if (tick) begin
            case (ph_r)
              2'b00: sda_lo_r <= (op_c == OP_T) && (bit_r != ACK_SLOT) && !sr_r[7];
              2'b01: scl_lo_r <= 1'b0;
              2'b10: begin
                if (op_c == OP_T && bit_r == ACK_SLOT) begin
                  rsp_nack_o <= sda;
                end
                if (op_c == OP_R && bit_r != ACK_SLOT) begin
                  rsp_rdata_o <= {rsp_rdata_o[6:0], sda};
                end
              end
              default: begin
                scl_lo_r <= 1'b1;
                sr_r <= {sr_r[6:0], 1'b0};
                bit_r <= bit_r + 4'h1;
                if (bit_r == ACK_SLOT) begin
                  step_r <= rsp_nack_o ? last_c : step_r + 3'd1;
                  st_r <= EH_NEXT;
                end
              end
            endcase
          end
        end
        EH_STOP: begin
          if (tick) begin
            case (ph_r)
              2'b00: sda_lo_r <= 1'b1;
              2'b01: scl_lo_r <= 1'b0;
              2'b10: sda_lo_r <= 1'b0;
              default: begin
                rsp_valid_o <= 1'b1;
                st_r <= EH_IDLE;
              end
            endcase
          end
        end
        default: st_r <= EH_IDLE;
      endcase
    end
  end

  assign cmd_ready_o      = (st_r == EH_IDLE);
  assign bus.host_scl_o   = 1'b0;
  assign bus.host_scl_oe  = scl_lo_r;
  assign bus.host_sda_o   = 1'b0;
  assign bus.host_sda_oe  = sda_lo_r;
endmodule : ee_host
`default_nettype wire

// ==== ee_link_properties.sv ====
`default_nettype none
module ee_link_properties #(
  parameter int WR_CYCLES = 400,
  parameter int PU_CYCLES = 10
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic dev_sda_o,
  input  wire logic dev_sda_oe,
  input  wire logic busy_o,
  input  wire logic ready_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [16:0] busy_cnt_r;
  logic [16:0] up_cnt_r;
  // The up counter restarts only in reset or while ready is high, so a supply loss only lengthens its wait.
  always_ff @(posedge clk_i) begin
    busy_cnt_r <= busy_o ? busy_cnt_r + 17'h1 : 17'h0;
    up_cnt_r   <= (sys_rst_i || ready_o) ? 17'h0 : up_cnt_r + 17'h1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  //////////////////////////////////////////////////////////////////////////////////////////
  open_drain_a: assert property (dev_sda_oe |-> !dev_sda_o)
    else $error("device drives the data line high");
  change_low_a: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device data changed while clock high");
  hold_high_a: assert property ($rose(dev_sda_oe) |-> !scl [*2])
    else $error("device drive started too late in the low phase");
  busy_quiet_a: assert property (busy_o |-> !dev_sda_oe)
    else $error("device drives the bus during the write cycle");
  unready_quiet_a: assert property (!ready_o |-> !dev_sda_oe)
    else $error("device drives the bus before it is ready");
  stop_commit_a: assert property ($rose(busy_o) |-> scl && !dev_sda_oe)
    else $error("write cycle began outside a stop");
  busy_bound_a: assert property (busy_o |-> busy_cnt_r <= WR_CYCLES)
    else $error("write cycle too long");
  busy_full_a: assert property ($fell(busy_o) |-> $past(busy_cnt_r) >= WR_CYCLES - 2)
    else $error("write cycle too short");
  ready_wait_a: assert property ($rose(ready_o) |-> up_cnt_r >= PU_CYCLES - 1)
    else $error("ready came before the power up delay");
  reset_quiet_a: assert property (disable iff (1'b0) sys_rst_i |=> !dev_sda_oe && !busy_o)
    else $error("device active during reset");
  cover property (scl && $fell(sda));
  cover property ($rose(dev_sda_oe));
  cover property ($rose(busy_o));
  cover property ($fell(ready_o));
endmodule : ee_link_properties
`default_nettype wire

// ==== eeprom_two_wire_slave_port_bench.sv ====
`default_nettype none
module eeprom_two_wire_slave_port_bench;
  import ee_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WRC = 400;
  localparam int PUC = 10;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        por_ok_i = 1'b1;
  logic        wp_i = 1'b0;
  logic [2:0]  strap = 3'h5;
  logic        cmd_valid_i = 1'b0;
  logic        cmd_read_i = 1'b0;
  logic [2:0]  cmd_dev_i = 3'h0;
  logic [11:0] cmd_addr_i = 12'h000;
  logic [7:0]  cmd_wdata_i = 8'h00;
  logic        mem_we_o, busy_o, ready_o;
  logic        cmd_ready_o, rsp_valid_o, rsp_nack_o;
  logic [11:0] mem_waddr_o, mem_raddr_o, we_adr;
  logic [7:0]  mem_wdata_o, mem_rdata_i, rsp_rdata_o, we_dat, mon_sh, mon_adr;
  logic [7:0]  mem [4096];
  logic [7:0]  shadow [4096];
  logic        scl_q = 1'b1;
  logic        sda_q = 1'b1;
  logic        mon_ack;
  int          mon_bits = 0;
  int          last_bits = 0;
  int          n_we = 0;
  int          n_errors = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          seed;
  always #25 clk_i = ~clk_i;
  ee_if link ();
  ee_dev #(.WR_CYCLES(WRC), .PU_CYCLES(PUC), .AW(MEM_AW)) ee_dev_inst (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus(link.dev), .por_ok_i(por_ok_i), .wp_i(wp_i),
    .select_strap_bit0_i(strap[0]), .select_strap_bit1_i(strap[1]),
    .select_strap_bit2_i(strap[2]), .mem_we_o(mem_we_o), .mem_waddr_o(mem_waddr_o),
    .mem_wdata_o(mem_wdata_o), .mem_raddr_o(mem_raddr_o), .mem_rdata_i(mem_rdata_i),
    .busy_o(busy_o), .ready_o(ready_o));
  ee_host #(.QTR(HOST_QTR), .PU_CYCLES(PUC), .AW(MEM_AW)) ee_host_inst (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus(link.host), .cmd_valid_i(cmd_valid_i),
    .cmd_ready_o(cmd_ready_o), .cmd_read_i(cmd_read_i), .cmd_dev_i(cmd_dev_i),
    .cmd_addr_i(cmd_addr_i), .cmd_wdata_i(cmd_wdata_i), .rsp_valid_o(rsp_valid_o),
    .rsp_nack_o(rsp_nack_o), .rsp_rdata_o(rsp_rdata_o));
  ee_link_properties #(.WR_CYCLES(WRC), .PU_CYCLES(PUC)) ee_link_properties_inst (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl(link.scl), .sda(link.sda),
    .dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe), .busy_o(busy_o),
    .ready_o(ready_o));
  //////////////////////////////////////////////////////////////////////////////////////////
  // The bench memory answers in the same cycle, as the device expects of its array.
  assign mem_rdata_i = mem[mem_raddr_o];
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (mem_we_o) begin
      mem[mem_waddr_o] <= mem_wdata_o;
      we_adr <= mem_waddr_o;
      we_dat <= mem_wdata_o;
      n_we <= n_we + 1;
    end
    scl_q <= link.scl;
    sda_q <= link.sda;
    if (link.scl && scl_q && sda_q && !link.sda) begin
      mon_bits <= 0;
    end else if (link.scl && scl_q && !sda_q && link.sda) begin
      last_bits <= mon_bits;
    end else if (link.scl && !scl_q) begin
      mon_bits <= mon_bits + 1;
      mon_sh <= {mon_sh[6:0], link.sda};
      if (mon_bits == 7) mon_adr <= {mon_sh[6:0], link.sda};
      if (mon_bits % 9 == 8) mon_ack <= link.sda;
    end
    if (cyc == 80000) begin
      n_errors++;
      $display("Error at %0t ns: run hung", $time);
      final_report();
    end
  end
  //////////////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] adr_byte(input logic [2:0] dev, input logic rd);
    return {DEV_TYPE, dev, rd};
  endfunction : adr_byte
  // Nine clocks per byte, plus the clock rise that leads into the STOP.
  function automatic int frame_clocks(input int n_bytes);
    return 9 * n_bytes + 1;
  endfunction : frame_clocks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t ns: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask : check
  task automatic run_cmd(input logic rd, input logic [2:0] dev, input logic [11:0] adr,
                         input logic [7:0] wd);
    int t;
    t = 0;
    @(posedge clk_i);
    #2;
    cmd_valid_i = 1'b1;
    cmd_read_i  = rd;
    cmd_dev_i   = dev;
    cmd_addr_i  = adr;
    cmd_wdata_i = wd;
    // Ready is judged just after each edge, so the command is taken exactly once.
    while (cmd_ready_o !== 1'b1 && t < 100) begin @(posedge clk_i); #2; t++; end
    @(posedge clk_i);
    #2;
    cmd_valid_i = 1'b0;
    while (rsp_valid_o !== 1'b1 && t < 3000) begin @(posedge clk_i); #1; t++; end
    check(t < 3000, 1'b1, "response wait");
  endtask : run_cmd
  task automatic wr_byte(input logic [2:0] dev, input logic [11:0] adr, input logic [7:0] d,
                         input logic ok);
    int t;
    int we0;
    we0 = n_we;
    t = 0;
    run_cmd(1'b0, dev, adr, d);
    check(rsp_nack_o, !ok, "write refusal");
    check(mon_adr, adr_byte(dev, 1'b0), "address byte");
    if (ok) check(last_bits, frame_clocks(4), "write clocks");
    repeat (8) @(posedge clk_i);
    while (busy_o !== 1'b0 && t < WRC + 50) begin @(posedge clk_i); t++; end
    check(n_we - we0, ok, "stored bytes");
    if (ok) check({we_adr, we_dat}, {adr, d}, "stored place");
    if (ok) shadow[adr] = d;
  endtask : wr_byte
  task automatic rd_byte(input logic [2:0] dev, input logic [11:0] adr);
    run_cmd(1'b1, dev, adr, 8'h00);
    check(rsp_nack_o, 1'b0, "read refusal");
    check(rsp_rdata_o, shadow[adr], "read data");
    check(last_bits, frame_clocks(2), "read clocks");
    check(mon_adr, adr_byte(dev, 1'b1), "read address byte");
    check(mon_ack, 1'b1, "master not_acknowledge");
    check(link.dev_sda_oe, 1'b0, "line released");
  endtask : rd_byte
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  //////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 73;
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 8'hff;
      shadow[i] = 8'hff;
    end
    repeat (4) @(posedge clk_i);
    #2;
    sys_rst_i = 1'b0;
    repeat (PUC + 8) @(posedge clk_i);
    check(ready_o, 1'b1, "ready after power up");
    #2;
    por_ok_i = 1'b0;
    @(posedge clk_i);
    #2;
    por_ok_i = 1'b1;
    repeat (6) @(posedge clk_i);
    check(ready_o, 1'b1, "one cycle supply dip filtered");
    #2;
    por_ok_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #2;
    por_ok_i = 1'b1;
    repeat (4) @(posedge clk_i);
    check(ready_o, 1'b0, "two cycle supply dip passed");
    repeat (PUC + 6) @(posedge clk_i);
    check(ready_o, 1'b1, "ready after dip");
    $display("Test power up and filter done");
    wr_byte(strap, 12'hfff, 8'h5a, 1'b1);
    rd_byte(strap, 12'hfff);
    wr_byte(strap, 12'h000, 8'ha5, 1'b1);
    rd_byte(strap, 12'h000);
    $display("Test boundary write and read done");
    run_cmd(1'b0, strap, 12'h123, 8'h3c);
    shadow[12'h123] = 8'h3c;
    run_cmd(1'b1, strap, 12'h123, 8'h00);
    check(rsp_nack_o, 1'b1, "polled while busy");
    repeat (WRC) @(posedge clk_i);
    rd_byte(strap, 12'h123);
    $display("Test acknowledge polling done");
    for (int b = 0; b < 3; b++) wr_byte(strap ^ (3'h1 << b), 12'h040, 8'h11, 1'b0);
    #2;
    wp_i = 1'b1;
    wr_byte(strap, 12'h041, 8'h22, 1'b0);
    #2;
    wp_i = 1'b0;
    rd_byte(strap, 12'h041);
    $display("Test refusals done");
    @(posedge clk_i);
    #2;
    por_ok_i = 1'b0;
    repeat (10) @(posedge clk_i);
    check(ready_o, 1'b0, "supply loss resets");
    #2;
    por_ok_i = 1'b1;
    repeat (PUC + 10) @(posedge clk_i);
    check(ready_o, 1'b1, "supply back");
    $display("Test supply loss done");
    for (int i = 0; i < 6; i++) begin
      #2;
      strap = 3'($random(seed));
      repeat (8) @(posedge clk_i);
      wr_byte(strap, 12'($random(seed)), 8'($random(seed)), 1'b1);
      rd_byte(strap, cmd_addr_i);
    end
    $display("Test random traffic done");
    final_report();
  end
endmodule : eeprom_two_wire_slave_port_bench
`default_nettype wire
